// >>> sbc_device.sv
// sdram die end: per-bank command decode and burst control
// Function
// - a3 zero: sequential order, lengths 1-page
// - a3 one: interleaved for 4 and 8
// - column command accepted every clock
// - a2..a0 select burst length
// - controller ends full-page bursts
// - controller meets row time at short ap
// - a9 one: writes are single word
// - controller meets row time single write
// - burst stop ends burst, read tail words
// - same-bank precharge stops burst, recovery two
// - no same-bank interrupt of auto-precharge burst
// - new column command restarts burst
// - idle: activate latches row
// - idle: refresh or mode write, all idle
// - active: column command begins burst, samples ap
// - nop lets burst finish to active
// - burst stop leaves bank active
// - write interrupts burst, resamples ap
// - precharge interrupts with read/write timing
// - ap burst: nop completes then precharges
// - clock enable assumed high
// - illegality is per bank
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
module sbc_device (
	input  wire logic                       clk,
	input  wire logic                       sys_rst,
	sbc_if.dev                              cmd,
	input  wire logic [1:0]                 cas_latency,
	output logic      [sbc_pkg::ADDR_W-1:0] mode_reg,
	output logic      [sbc_pkg::BANK_W-1:0] burst_bank,
	output logic      [sbc_pkg::COL_W-1:0]  burst_col,
	output logic                            rd_valid,
	output logic                            wr_valid,
	output logic                            illegal,
	output logic      [sbc_pkg::NUM_BANKS*3-1:0] bank_states
);
	import sbc_pkg::*;
	sbc_bank_t        bank [NUM_BANKS];
	logic [1:0]       pre_cnt [NUM_BANKS];
	logic [12:0]      row_addr [NUM_BANKS];
	sbc_cmd_t         op;
	logic             burst_on;
	logic             burst_wr;
	logic [BANK_W-1:0] cur_bank;
	logic [COL_W-1:0] start_col;
	logic [COL_W-1:0] step;
	logic [COL_W-1:0] next_col;
	logic [9:0]       remain;
	logic [9:0]       len_words;
	logic [1:0]       rd_tail;
	logic             all_idle;
	logic             hit_end;
	sbc_bank_t        sel;
	// command decoded from the pin levels
	always_comb begin
		if (cmd.cs_n)
			op = SBC_CMD_DESEL;
		else
			op = sbc_cmd_t'({1'b0, cmd.ras_n, cmd.cas_n, cmd.we_n});
	end
	assign sel = bank[cmd.ba];
	always_comb begin
		all_idle = 1'b1;
		for (int i = 0; i < NUM_BANKS; i++)
			if (bank[i] != SBC_IDLE)
				all_idle = 1'b0;
	end
	always_comb begin
		case (mode_reg[2:0])
			BL_1:    len_words = 10'h001;
			BL_2:    len_words = 10'h002;
			BL_4:    len_words = 10'h004;
			BL_8:    len_words = 10'h008;
			BL_PAGE: len_words = PAGE_LEN;
			default: len_words = 10'h001;
		endcase
		if (op == SBC_CMD_WRITE && mode_reg[BURST_READ_SINGLE_WRITE_BIT])
			len_words = 10'h001;
	end
	// full page never ends, except a single-word write
	assign hit_end = burst_on && remain == 10'h001 &&
	                 (mode_reg[2:0] != BL_PAGE || (burst_wr && mode_reg[BURST_READ_SINGLE_WRITE_BIT]));
	sbc_burst_addr u_addr (
		.interleave  (mode_reg[BT_BIT]),
		.burst_len   (burst_wr && mode_reg[BURST_READ_SINGLE_WRITE_BIT] ? BL_1 : mode_reg[2:0]),
		.start_col   (start_col),
		.step        (step),
		.column_addr (next_col)
	);
	// mode register write from all-idle
	always_ff @(posedge clk) begin
		if (sys_rst)
			mode_reg <= MODE_RESET;
		else if (op == SBC_CMD_MRS && all_idle)
			mode_reg <= cmd.addr;
	end
	// burst engine
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			burst_on  <= 1'b0;
			burst_wr  <= 1'b0;
			cur_bank  <= '0;
			start_col <= '0;
			step      <= '0;
			remain    <= '0;
			rd_tail   <= 2'h0;
		end else begin
			if (rd_tail != 2'h0)
				rd_tail <= rd_tail - 2'h1;
			if ((op == SBC_CMD_READ || op == SBC_CMD_WRITE) &&
			    (sel == SBC_ACTIVE || sel == SBC_READ || sel == SBC_WRITE)) begin
				burst_on  <= 1'b1;
				burst_wr  <= (op == SBC_CMD_WRITE);
				cur_bank  <= cmd.ba;
				start_col <= cmd.addr[COL_W-1:0];
				step      <= '0;
				remain    <= len_words;
			end else if (burst_on && (op == SBC_CMD_STOP ||
			             (op == SBC_CMD_PRE && cmd.ba == cur_bank &&
			              (bank[cur_bank] == SBC_READ || bank[cur_bank] == SBC_WRITE)))) begin
				burst_on <= 1'b0;
				if (!burst_wr)
					rd_tail <= cas_latency - 2'h1;
			end else if (burst_on) begin
				step   <= step + 9'h001;
				remain <= remain - 10'h001;
				if (hit_end)
					burst_on <= 1'b0;
			end
		end
	end
	// per-bank state machines
	generate
		for (genvar b = 0; b < NUM_BANKS; b++) begin : g_bank
			logic mine;
			logic ends;
			assign mine = !cmd.cs_n && cmd.ba == b;
			assign ends = hit_end && cur_bank == b;
			always_ff @(posedge clk) begin
				if (sys_rst) begin
					bank[b]     <= SBC_IDLE;
					pre_cnt[b]  <= 2'h0;
					row_addr[b] <= '0;
				end else begin
					case (bank[b])
						SBC_IDLE: begin
							if (mine && op == SBC_CMD_ACT) begin
								bank[b]     <= SBC_ACTIVE;
								row_addr[b] <= cmd.addr;
							end
						end
						SBC_ACTIVE, SBC_READ, SBC_WRITE: begin
							if (mine && (op == SBC_CMD_READ || op == SBC_CMD_WRITE)) begin
								if (cmd.addr[AP_BIT])
									bank[b] <= op == SBC_CMD_READ ? SBC_READ_AP : SBC_WRITE_AP;
								else
									bank[b] <= op == SBC_CMD_READ ? SBC_READ : SBC_WRITE;
							end else if (mine && op == SBC_CMD_PRE) begin
								bank[b]    <= SBC_PRECH;
								pre_cnt[b] <= bank[b] == SBC_WRITE ? PRE_WRITE_CYC : PRE_READ_CYC;
							end else if (op == SBC_CMD_STOP && bank[b] != SBC_ACTIVE &&
							             cur_bank == b) begin
								bank[b] <= SBC_ACTIVE;
							end else if (ends || (cur_bank == b && !burst_on &&
							             bank[b] != SBC_ACTIVE)) begin
								bank[b] <= SBC_ACTIVE;
							end else if (cur_bank != b && bank[b] != SBC_ACTIVE &&
							             (op == SBC_CMD_READ || op == SBC_CMD_WRITE)) begin
								bank[b] <= SBC_ACTIVE;
							end
						end
						SBC_READ_AP, SBC_WRITE_AP: begin
							if (ends || (cur_bank != b) || !burst_on) begin
								bank[b]    <= SBC_PRECH;
								pre_cnt[b] <= PRE_AP_CYC;
							end
						end
						SBC_PRECH: begin
							if (pre_cnt[b] == 2'h0)
								bank[b] <= SBC_IDLE;
							else
								pre_cnt[b] <= pre_cnt[b] - 2'h1;
						end
						default: bank[b] <= SBC_IDLE;
					endcase
				end
			end
			assign bank_states[b*3 +: 3] = bank[b];
		end
	endgenerate
	// registered observation outputs
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			burst_bank <= '0;
			burst_col  <= '0;
			rd_valid   <= 1'b0;
			wr_valid   <= 1'b0;
			illegal    <= 1'b0;
		end else begin
			burst_bank <= cur_bank;
			burst_col  <= next_col;
			rd_valid   <= (burst_on && !burst_wr) || rd_tail != 2'h0;
			wr_valid   <= burst_on && burst_wr;
			illegal    <= 1'b0;
			case (sel)
				SBC_IDLE:   illegal <= op == SBC_CMD_STOP || op == SBC_CMD_READ ||
				                       op == SBC_CMD_WRITE ||
				                       ((op == SBC_CMD_REF || op == SBC_CMD_MRS) && !all_idle);
				SBC_ACTIVE: illegal <= op == SBC_CMD_STOP || op == SBC_CMD_ACT ||
				                       op == SBC_CMD_REF || op == SBC_CMD_MRS;
				SBC_READ, SBC_WRITE:
				            illegal <= op == SBC_CMD_ACT || op == SBC_CMD_REF ||
				                       op == SBC_CMD_MRS;
				SBC_READ_AP, SBC_WRITE_AP:
				            illegal <= op != SBC_CMD_NOP && op != SBC_CMD_DESEL;
				default:    illegal <= 1'b0;
			endcase
		end
	end
endmodule : sbc_device

// >>> sbc_pkg.sv
// shared constants and types for the sdram burst command decode block
package sbc_pkg;
	localparam int NUM_BANKS = 4;
	localparam int BANK_W    = 2;
	localparam int ADDR_W    = 13;
	localparam int COL_W     = 9;
	localparam int DATA_W    = 16;
	localparam int AP_BIT    = 10;
	localparam int BT_BIT    = 3;
	localparam int BURST_READ_SINGLE_WRITE_BIT  = 9;
	localparam logic [2:0] BL_1    = 3'h0;
	localparam logic [2:0] BL_2    = 3'h1;
	localparam logic [2:0] BL_4    = 3'h2;
	localparam logic [2:0] BL_8    = 3'h3;
	localparam logic [2:0] BL_PAGE = 3'h7;
	localparam logic [ADDR_W-1:0] MODE_RESET = 13'h0032;
	localparam int LAST_WRITE_TO_STOP_DELAY = 1;
	localparam int WRITE_RECOVERY_DELAY     = 2;
	localparam logic [1:0] PRE_READ_CYC  = 2'h1;
	localparam logic [1:0] PRE_WRITE_CYC = 2'h2;
	localparam logic [1:0] PRE_AP_CYC    = 2'h2;
	localparam logic [9:0] PAGE_LEN  = 10'h200;
	// cs_n, ras_n, cas_n, we_n
	typedef enum logic [3:0] {
		SBC_CMD_NOP   = 4'h7,
		SBC_CMD_STOP  = 4'h6,
		SBC_CMD_READ  = 4'h5,
		SBC_CMD_WRITE = 4'h4,
		SBC_CMD_ACT   = 4'h3,
		SBC_CMD_PRE   = 4'h2,
		SBC_CMD_REF   = 4'h1,
		SBC_CMD_MRS   = 4'h0,
		SBC_CMD_DESEL = 4'h8
	} sbc_cmd_t;
	typedef enum logic [2:0] {
		SBC_IDLE    = 3'h0,
		SBC_ACTIVE  = 3'h1,
		SBC_READ    = 3'h3,
		SBC_WRITE   = 3'h2,
		SBC_READ_AP = 3'h6,
		SBC_WRITE_AP= 3'h7,
		SBC_PRECH   = 3'h5
	} sbc_bank_t;
endpackage : sbc_pkg

// >>> sbc_if.sv
// command pins between controller and sdram die
`timescale 1ns/1ps
interface sbc_if;
	import sbc_pkg::*;
	logic              cs_n;
	logic              ras_n;
	logic              cas_n;
	logic              we_n;
	logic [BANK_W-1:0] ba;
	logic [ADDR_W-1:0] addr;
	modport ctrl (output cs_n, ras_n, cas_n, we_n, ba, addr);
	modport dev  (input cs_n, ras_n, cas_n, we_n, ba, addr);
endinterface : sbc_if

// >>> sbc_burst_addr.sv
// burst column address generator, sequential or interleaved
`timescale 1ns/1ps
module sbc_burst_addr (
	input  wire logic                 interleave,
	input  wire logic [2:0]           burst_len,
	input  wire logic [sbc_pkg::COL_W-1:0] start_col,
	input  wire logic [sbc_pkg::COL_W-1:0] step,
	output logic      [sbc_pkg::COL_W-1:0] column_addr
);
	import sbc_pkg::*;
	logic [COL_W-1:0] mask;
	always_comb begin
		case (burst_len)
			BL_2:    mask = 9'h001;
			BL_4:    mask = 9'h003;
			BL_8:    mask = 9'h007;
			BL_PAGE: mask = 9'h1ff;
			default: mask = 9'h000;
		endcase
	end
	always_comb begin
		if (interleave && (burst_len == BL_4 || burst_len == BL_8))
			column_addr = (start_col & ~mask) | ((start_col ^ step) & mask);
		else
			column_addr = (start_col & ~mask) | ((start_col + step) & mask);
	end
endmodule : sbc_burst_addr

// >>> sbc_ctrl.sv
// controller end: register port drives one command per write
`timescale 1ns/1ps
module sbc_ctrl (
	input  wire logic        clk,
	input  wire logic        sys_rst,
	sbc_if.ctrl              cmd,
	input  wire logic [3:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [31:0] reg_rdata
);
	import sbc_pkg::*;
	localparam logic [3:0] REG_CMD  = 4'h0;
	localparam logic [3:0] REG_STAT = 4'h4;
	logic [15:0] issued;
	// one command issued per write, nop otherwise
	always_ff @(posedge clk) begin
		if (sys_rst) begin
			{cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= 4'hf;
			cmd.ba   <= '0;
			cmd.addr <= '0;
			issued   <= '0;
		end else if (reg_wr && reg_addr == REG_CMD) begin
			{cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= reg_wdata[19:16];
			cmd.ba   <= reg_wdata[21:20];
			cmd.addr <= reg_wdata[12:0];
			issued   <= issued + 16'h0001;
		end else begin
			{cmd.cs_n, cmd.ras_n, cmd.cas_n, cmd.we_n} <= 4'h7;
		end
	end
	always_ff @(posedge clk) begin
		if (sys_rst)
			reg_rdata <= '0;
		else if (reg_rd && reg_addr == REG_STAT)
			reg_rdata <= {16'h0000, issued};
		else
			reg_rdata <= '0;
	end
endmodule : sbc_ctrl

// >>> sbc_properties.sv
// pin and status properties for the sdram command link
`timescale 1ns/1ps
module sbc_properties (
	input wire logic        clk,
	input wire logic        sys_rst,
	input wire logic        cs_n,
	input wire logic        ras_n,
	input wire logic        cas_n,
	input wire logic        we_n,
	input wire logic [1:0]  ba,
	input wire logic [12:0] addr,
	input wire logic [12:0] mode_reg,
	input wire logic        rd_valid,
	input wire logic        wr_valid,
	input wire logic        illegal,
	input wire logic [11:0] bank_states
);
	import sbc_pkg::*;
	logic [3:0] pc;
	logic [2:0] cur;
	logic [2:0] nxt;
	logic [1:0] ba_q;
	assign pc = {cs_n, ras_n, cas_n, we_n};
	assign cur = bank_states[int'(ba)*3 +: 3];
	assign nxt = bank_states[int'(ba_q)*3 +: 3];
	always_ff @(posedge clk) ba_q <= ba;
	default clocking cb @(posedge clk); endclocking
	default disable iff (sys_rst);
	property p_mode;
		pc == SBC_CMD_MRS && bank_states == 12'h0 |=> mode_reg == $past(addr);
	endproperty
	a_mode: assert property (p_mode) else $error("mode word not loaded");
	property p_act;
		pc == SBC_CMD_ACT && cur == SBC_IDLE |=> nxt == SBC_ACTIVE;
	endproperty
	a_act: assert property (p_act) else $error("bank not opened");
	property p_ap;
		pc == SBC_CMD_READ && cur == SBC_ACTIVE && addr[AP_BIT] |=> nxt == SBC_READ_AP;
	endproperty
	a_ap: assert property (p_ap) else $error("auto precharge flag lost");
	property p_ap_ill;
		(pc == SBC_CMD_READ || pc == SBC_CMD_WRITE || pc == SBC_CMD_PRE)
			&& cur inside {SBC_READ_AP, SBC_WRITE_AP} |=> illegal;
	endproperty
	a_ap_ill: assert property (p_ap_ill) else $error("ap burst interrupt not flagged");
	property p_idle_ill;
		pc == SBC_CMD_READ && cur == SBC_IDLE |=> illegal;
	endproperty
	a_idle_ill: assert property (p_idle_ill) else $error("read to idle bank not flagged");
	property p_pre;
		pc == SBC_CMD_PRE && cur inside {SBC_READ, SBC_WRITE} |=> nxt == SBC_PRECH;
	endproperty
	a_pre: assert property (p_pre) else $error("precharge did not end burst");
	property p_bl4;
		pc == SBC_CMD_READ && cur == SBC_ACTIVE && mode_reg[2:0] == BL_4
			|-> ##2 rd_valid [*4];
	endproperty
	a_bl4: assert property (p_bl4) else $error("four word read short");
	property p_burst_read_single_write;
		pc == SBC_CMD_WRITE && cur == SBC_ACTIVE && mode_reg[BURST_READ_SINGLE_WRITE_BIT]
			|-> ##2 wr_valid ##1 !wr_valid;
	endproperty
	a_burst_read_single_write: assert property (p_burst_read_single_write) else $error("single write not single");
	property p_stop;
		pc == SBC_CMD_STOP |-> ##[1:4] (!rd_valid && !wr_valid);
	endproperty
	a_stop: assert property (p_stop) else $error("burst stop ignored");
endmodule : sbc_properties

// >>> sdram_burst_command_decode_test.sv
// self-checking bench for the sdram command link
`timescale 1ns/1ps
module sdram_burst_command_decode_test;
	import sbc_pkg::*;
	logic        clk = 1'b0;
	logic        sys_rst = 1'b1;
	logic [3:0]  reg_addr = 4'h0;
	logic [31:0] reg_wdata = 32'h0;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic [12:0] mode_reg;
	logic [8:0]  burst_col;
	logic [1:0]  burst_bank;
	logic        rd_valid, wr_valid, illegal;
	logic [11:0] bank_states;
	logic [8:0]  cols [$];
	int          err_total = 0, num_checks = 0, ill_cnt = 0, n_cmd = 0;
	sbc_if bus ();
	always #10 clk = ~clk;
	sbc_ctrl u_sbc_ctrl (.clk(clk), .sys_rst(sys_rst), .cmd(bus.ctrl), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata));
	sbc_device u_sbc_device (.clk(clk), .sys_rst(sys_rst), .cmd(bus.dev),
		.cas_latency(mode_reg[5:4]), .mode_reg(mode_reg), .burst_bank(burst_bank),
		.burst_col(burst_col), .rd_valid(rd_valid),
		.wr_valid(wr_valid), .illegal(illegal), .bank_states(bank_states));
	sbc_properties u_sbc_properties (.clk(clk), .sys_rst(sys_rst), .cs_n(bus.cs_n),
		.ras_n(bus.ras_n), .cas_n(bus.cas_n), .we_n(bus.we_n), .ba(bus.ba), .addr(bus.addr),
		.mode_reg(mode_reg), .rd_valid(rd_valid), .wr_valid(wr_valid), .illegal(illegal),
		.bank_states(bank_states));
	always @(posedge clk) begin
		if (illegal === 1'b1) ill_cnt++;
		if (rd_valid === 1'b1 || wr_valid === 1'b1) cols.push_back(burst_col);
	end
	task chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			err_total++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk
	task cmd(input logic [1:0] b, input logic [3:0] c, input logic [12:0] a);
		@(posedge clk);
		reg_addr <= 4'h0;
		reg_wdata <= {10'h0, b, c, 3'h0, a};
		reg_wr <= 1'b1;
		n_cmd++;
	endtask : cmd
	task gap(input int n);
		@(posedge clk);
		reg_wr <= 1'b0;
		repeat (n) @(posedge clk);
		#1;
	endtask : gap
	task rd_reg(input logic [3:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clk);
		reg_rd <= 1'b0;
		#1 chk(reg_rdata, exp);
	endtask : rd_reg
	task setmode(input logic [12:0] m);
		cmd(2'h0, SBC_CMD_PRE, 13'h400);
		gap(4);
		cmd(2'h0, SBC_CMD_MRS, m);
		gap(3);
		chk(mode_reg, m);
		cmd(2'h0, SBC_CMD_ACT, 13'h0);
		gap(2);
		chk(bank_states[2:0], SBC_ACTIVE);
		cols = {};
	endtask : setmode
	function automatic logic [8:0] exp_col(input logic il, input logic [8:0] len, input int k);
		logic [8:0] w;
		w = il ? (9'h5 ^ k[8:0]) : (9'h5 + k[8:0]);
		return (9'h5 & ~(len - 9'h1)) | (w & (len - 9'h1));
	endfunction : exp_col
	task t_bursts;
		logic [8:0] len;
		for (int i = 0; i < 8; i++) begin
			len = 9'h1 << i[2:1];
			setmode({6'h0, 3'h3, i[0], 1'b0, i[2:1]});
			cmd(2'h0, SBC_CMD_READ, 13'h5);
			gap(12);
			chk(cols.size(), len);
			foreach (cols[k]) chk(cols[k], exp_col(i[0], len, k));
			chk(bank_states[2:0], SBC_ACTIVE);
		end
		$display("bursts done");
	endtask : t_bursts
	task t_misc;
		setmode(13'h0232);
		cmd(2'h0, SBC_CMD_WRITE, 13'h400);
		gap(6);
		chk(cols.size(), 1);
		chk(bank_states[2:0], SBC_IDLE);
		setmode(13'h0033);
		cmd(2'h0, SBC_CMD_READ, 13'h0);
		cmd(2'h0, SBC_CMD_READ, 13'h8);
		gap(14);
		chk(cols.size(), 9);
		chk(cols[8], 9'h0f);
		for (int c = 0; c < 2; c++) begin
			setmode(c ? 13'h0027 : 13'h0037);
			cmd(2'h0, SBC_CMD_READ, 13'h0);
			gap(40);
			chk(rd_valid, 1'b1);
			cols = {};
			cmd(2'h0, SBC_CMD_STOP, 13'h0);
			gap(6);
			chk(cols.size(), c ? 32'h5 : 32'h6);
			chk(rd_valid, 1'b0);
			chk(bank_states[2:0], SBC_ACTIVE);
		end
		for (int j = 0; j < 2; j++) begin
			setmode(13'h0033);
			cmd(2'h0, j ? SBC_CMD_WRITE : SBC_CMD_READ, 13'h0);
			gap(1);
			cmd(2'h0, SBC_CMD_PRE, 13'h0);
			gap(6);
			chk({rd_valid, wr_valid, bank_states[2:0]}, SBC_IDLE);
		end
		$display("interrupts done");
	endtask : t_misc
	task t_ap;
		setmode(13'h0031);
		cmd(2'h1, SBC_CMD_ACT, 13'h0);
		gap(2);
		ill_cnt = 0;
		cmd(2'h0, SBC_CMD_READ, 13'h400);
		gap(0);
		cmd(2'h0, SBC_CMD_READ, 13'h0);
		gap(10);
		chk(ill_cnt, 1);
		chk(bank_states[2:0], SBC_IDLE);
		cmd(2'h1, SBC_CMD_READ, 13'h0);
		gap(8);
		chk(ill_cnt, 1);
		chk(burst_bank, 2'h1);
		cmd(2'h0, SBC_CMD_READ, 13'h0);
		gap(2);
		chk(ill_cnt, 2);
		cmd(2'h0, SBC_CMD_REF, 13'h0);
		cmd(2'h1, SBC_CMD_ACT, 13'h0);
		gap(2);
		chk(ill_cnt, 4);
		rd_reg(4'h4, n_cmd);
		rd_reg(4'h8, 32'h0);
		$display("auto precharge done");
	endtask : t_ap
	task print_verdict;
		$display("checks %0d errors %0d", num_checks, err_total);
		if (err_total == 0 && num_checks > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask : print_verdict
	initial begin
		repeat (3) @(posedge clk);
		#1 chk({bus.cs_n, bus.ras_n, bus.cas_n, bus.we_n, bank_states}, 16'hf000);
		chk(mode_reg, MODE_RESET);
		@(posedge clk);
		sys_rst <= 1'b0;
		t_bursts();
		t_misc();
		t_ap();
		print_verdict();
	end
	initial begin
		#100000;
		err_total++;
		print_verdict();
	end
endmodule : sdram_burst_command_decode_test
